// >>> psmp_pkg.sv
package psmp_pkg;

  // Word addresses of the per-space secondary control registers, spaces 0 to 3.
  localparam logic [31:0] PSMP_SEC_ADDR0 = 32'h0180_0048;
  localparam logic [31:0] PSMP_SEC_ADDR1 = 32'h0180_0044;
  localparam logic [31:0] PSMP_SEC_ADDR2 = 32'h0180_0050;
  localparam logic [31:0] PSMP_SEC_ADDR3 = 32'h0180_0054;

  // Field positions inside a secondary control word.
  localparam int PSMP_RL_LSB = 0;
  localparam int PSMP_WL_LSB = 2;
  localparam int PSMP_EXT_BIT = 4;
  localparam int PSMP_STB_BIT = 5;
  localparam int PSMP_CSEL_BIT = 6;
  localparam int PSMP_SEC_W = 7;

  // Divider codes for the second memory clock.
  localparam logic [1:0] PSMP_DIV_1 = 2'h0;
  localparam logic [1:0] PSMP_DIV_2 = 2'h1;
  localparam logic [1:0] PSMP_DIV_4 = 2'h2;

  // Widths of the external buses.
  localparam int PSMP_AW = 20;
  localparam int PSMP_DW = 64;
  localparam int PSMP_BW = 8;
  localparam int PSMP_NSP = 4;

  // One space's synchronous-mode settings, msb first.
  typedef struct packed {
    logic sync_clock_select;
    logic strobe_function_bit;
    logic select_extend_bit;
    logic [1:0] write_latency_field;
    logic [1:0] read_latency_field;
  } psmp_sec_t;

  localparam psmp_sec_t PSMP_SEC_RST = '0;

  // One access request as taken from the user side.
  typedef struct packed {
    logic we;
    logic [1:0] space;
    logic [PSMP_AW-1:0] addr;
    logic [PSMP_BW-1:0] be;
    logic [PSMP_DW-1:0] wdata;
  } psmp_req_t;

  typedef enum logic [1:0] {
    PSMP_IDLE,
    PSMP_ARM,
    PSMP_LAT,
    PSMP_FIN
  } psmp_state_t;

endpackage

// >>> psmp_top.sv
`timescale 1ns/1ns
module psmp_top
  import psmp_pkg::*;
(
  input wire logic I_CLK, // Interface input clock, 125 MHz.
  input wire logic I_RST_B, // Asynchronous reset, active low.
  input wire logic i_CFG_WE, // Secondary register write strobe.
  input wire logic [31:0] i_CFG_ADDR, // Secondary register word address.
  input wire logic [31:0] i_CFG_WDATA, // Secondary register write data.
  output logic [31:0] o_CFG_RDATA, // Registered read-back of the addressed register.
  input wire logic [1:0] i_CLK2_DIV, // Divider code for the second memory clock.
  input wire logic i_REQ_VALID, // Access request present.
  output logic o_REQ_READY, // Access request taken when high with valid.
  input wire psmp_req_t i_REQ, // Access request contents.
  output logic o_RD_VALID, // One-cycle pulse with read data.
  output logic [PSMP_DW-1:0] o_RD_DATA, // Captured read data.
  output logic o_BUSY, // An access is in progress.
  output logic o_MCLK_ONE, // Memory clock out one.
  output logic o_MCLK_TWO, // Memory clock out two.
  output logic [PSMP_NSP-1:0] o_CS_N, // Space chip selects, active low.
  output logic [PSMP_AW-1:0] o_EA, // External address bus.
  output logic [PSMP_BW-1:0] o_BE_N, // External byte enables, active low.
  output logic [PSMP_DW-1:0] o_ED_OUT, // External data bus, driven value.
  output logic o_ED_OE, // External data bus output enable.
  input wire logic [PSMP_DW-1:0] i_ED_IN, // External data bus, pin level.
  output logic o_ADS_RE_N, // Address strobe or read enable, active low.
  output logic o_OE_N, // Sync output enable, active low.
  output logic o_WE_N // Sync write enable, active low.
);

  logic rst_meta_q;
  logic rst_n;
  logic div1_q;
  logic [1:0] cnt2_q;
  logic mclk2_q;
  logic tick1;
  logic tick2;
  logic tick;
  logic [PSMP_DW-1:0] ed_meta_q;
  logic [PSMP_DW-1:0] ed_sync_q;
  psmp_sec_t sec_q [PSMP_NSP];
  psmp_sec_t cur_q;
  psmp_req_t req_q;
  psmp_state_t state_q;
  logic [2:0] el_q;
  logic [1:0] cfg_idx;
  logic cfg_hit;

  // Reset is released through two flip-flops so every register leaves reset together.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Memory clock one toggles every input cycle; clock two divides it by 1, 2 or 4.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div1_q <= 1'b0;
      cnt2_q <= 2'h0;
      mclk2_q <= 1'b0;
    end else begin
      div1_q <= ~div1_q;
      if (tick1) begin
        cnt2_q <= cnt2_q + 2'h1;
      end
      if (tick2) begin
        mclk2_q <= 1'b1;
      end else if (i_CLK2_DIV == PSMP_DIV_1) begin
        mclk2_q <= ~div1_q;
      end else if (i_CLK2_DIV == PSMP_DIV_2) begin
        mclk2_q <= tick1 ? ~cnt2_q[0] : cnt2_q[0];
      end else begin
        mclk2_q <= tick1 ? (cnt2_q[1] ^ cnt2_q[0]) : cnt2_q[1];
      end
    end
  end

  // A tick marks the input edge on which a memory clock rises; outputs change there.
  assign tick1 = ~div1_q;
  assign tick2 = tick1 && ((i_CLK2_DIV == PSMP_DIV_1) ||
                 ((i_CLK2_DIV == PSMP_DIV_2) && !cnt2_q[0]) ||
                 ((i_CLK2_DIV != PSMP_DIV_1) && (i_CLK2_DIV != PSMP_DIV_2) &&
                  (cnt2_q == 2'h1)));
  assign tick = cur_q.sync_clock_select ? tick2 : tick1;
  assign o_MCLK_ONE = div1_q;
  assign o_MCLK_TWO = mclk2_q;

  // Read data arrives from pins, so it passes two flip-flops before use.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ed_meta_q <= '0;
      ed_sync_q <= '0;
    end else begin
      ed_meta_q <= i_ED_IN;
      ed_sync_q <= ed_meta_q;
    end
  end

  // Address decode of the four secondary registers.
  always_comb begin
    cfg_hit = 1'b1;
    cfg_idx = 2'h0;
    case (i_CFG_ADDR)
      PSMP_SEC_ADDR0: cfg_idx = 2'h0;
      PSMP_SEC_ADDR1: cfg_idx = 2'h1;
      PSMP_SEC_ADDR2: cfg_idx = 2'h2;
      PSMP_SEC_ADDR3: cfg_idx = 2'h3;
      default: cfg_hit = 1'b0;
    endcase
  end

  // One settings register per space; an unmapped address is ignored and reads zero.
  generate
    for (genvar s = 0; s < PSMP_NSP; s++) begin : g_sec
      always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
          sec_q[s] <= PSMP_SEC_RST;
        end else if (i_CFG_WE && cfg_hit && (cfg_idx == 2'(s))) begin
          sec_q[s] <= psmp_sec_t'(i_CFG_WDATA[PSMP_SEC_W-1:0]);
        end
      end
    end
  endgenerate

  // Registered read-back, upper bits zero.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      o_CFG_RDATA <= 32'h0;
    end else if (cfg_hit) begin
      o_CFG_RDATA <= {{(32-PSMP_SEC_W){1'b0}}, sec_q[cfg_idx]};
    end else begin
      o_CFG_RDATA <= 32'h0;
    end
  end

  // Requests are taken only when idle; the settings of the space are frozen per access.
  assign o_REQ_READY = (state_q == PSMP_IDLE);
  assign o_BUSY = (state_q != PSMP_IDLE);

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
      cur_q <= PSMP_SEC_RST;
    end else if (i_REQ_VALID && o_REQ_READY) begin
      req_q <= i_REQ;
      cur_q <= sec_q[i_REQ.space];
    end
  end

  // Access sequencer; every pin change is made on a tick of the selected clock.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PSMP_IDLE;
      el_q <= 3'h0;
      o_CS_N <= '1;
      o_EA <= '0;
      o_BE_N <= '1;
      o_ED_OUT <= '0;
      o_ED_OE <= 1'b0;
      o_ADS_RE_N <= 1'b1;
      o_OE_N <= 1'b1;
      o_WE_N <= 1'b1;
      o_RD_VALID <= 1'b0;
      o_RD_DATA <= '0;
    end else begin
      o_RD_VALID <= 1'b0;
      case (state_q)
        PSMP_IDLE: begin
          if (tick) begin
            o_ADS_RE_N <= 1'b1; // Ends any deselect cycle.
          end
          if (i_REQ_VALID) begin
            state_q <= PSMP_ARM;
          end
        end
        PSMP_ARM: begin
          if (tick) begin
            // Command cycle: select, address and the strobe roles of the shared pins.
            o_CS_N <= ~(4'h1 << req_q.space);
            o_EA <= req_q.addr;
            o_ADS_RE_N <= (cur_q.strobe_function_bit && req_q.we);
            o_WE_N <= ~req_q.we;
            o_OE_N <= req_q.we;
            o_BE_N <= req_q.we ? '1 : '0;
            el_q <= 3'h1;
            state_q <= PSMP_LAT;
            if (req_q.we && (cur_q.write_latency_field == 2'h0)) begin
              o_ED_OUT <= req_q.wdata;
              o_ED_OE <= 1'b1;
              o_BE_N <= ~req_q.be;
              state_q <= PSMP_FIN;
            end
          end
        end
        PSMP_LAT: begin
          if (tick) begin
            o_ADS_RE_N <= 1'b1;
            o_WE_N <= 1'b1;
            el_q <= el_q + 3'h1;
            // Without extension the select falls back right after the command.
            if (!cur_q.select_extend_bit || req_q.we) begin
              o_CS_N <= '1;
            end
            if (req_q.we) begin
              o_BE_N <= '1;
              if (el_q == {1'b0, cur_q.write_latency_field}) begin
                o_ED_OUT <= req_q.wdata;
                o_ED_OE <= 1'b1;
                o_BE_N <= ~req_q.be;
                state_q <= PSMP_FIN;
              end
            end else if (el_q == ({1'b0, cur_q.read_latency_field} + 3'h1)) begin
              // Data of the edge that closes the latency window.
              o_RD_DATA <= ed_sync_q;
              o_RD_VALID <= 1'b1;
              o_OE_N <= 1'b1;
              o_BE_N <= '1;
              o_CS_N <= '1;
              state_q <= PSMP_FIN;
            end
          end
        end
        PSMP_FIN: begin
          if (tick) begin
            // Deselect cycle; with the strobe function bit set ADS/RE stays high and no deselect is issued.
            o_CS_N <= '1;
            o_ED_OE <= 1'b0;
            o_BE_N <= '1;
            o_WE_N <= 1'b1;
            o_OE_N <= 1'b1;
            o_ADS_RE_N <= cur_q.strobe_function_bit;
            state_q <= PSMP_IDLE;
          end
        end
        default: begin
          state_q <= PSMP_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> psmp_assertions.sv
`timescale 1ns/1ns
module psmp_assertions
  import psmp_pkg::*;
(
  input wire logic I_CLK, // Clock.
  input wire logic I_RST_B, // Reset.
  input wire logic [31:0] i_CFG_ADDR, // Address.
  input wire logic [31:0] o_CFG_RDATA, // Read-back.
  input wire logic o_RD_VALID, // Read pulse.
  input wire logic o_MCLK_ONE, // Clock one.
  input wire logic o_MCLK_TWO, // Clock two.
  input wire logic [PSMP_NSP-1:0] o_CS_N, // Selects.
  input wire logic o_OE_N, // Output enable.
  input wire logic o_WE_N, // Write enable.
  input wire logic o_ED_OE // Data drive.
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  logic hit;
  // Decode of the four register words.
  assign hit = i_CFG_ADDR inside {PSMP_SEC_ADDR0, PSMP_SEC_ADDR1, PSMP_SEC_ADDR2, PSMP_SEC_ADDR3};
  // Steps of clock one and of a command launch.
  sequence low_high_s; !o_MCLK_ONE ##1 o_MCLK_ONE; endsequence
  sequence cmd_s; $fell(o_OE_N) || $fell(o_WE_N); endsequence
  unmap_zero_a: assert property (!hit |=> o_CFG_RDATA == 32'h0)
    else $error("unmapped word nonzero");
  one_select_a: assert property ($onehot0(~o_CS_N))
    else $error("two selects low");
  rd_pulse_a: assert property (o_RD_VALID |=> !o_RD_VALID)
    else $error("read pulse too long");
  rd_end_a: assert property (o_RD_VALID |-> $rose(o_OE_N))
    else $error("read result off window");
  clk_one_a: assert property (o_MCLK_ONE |=> low_high_s)
    else $error("clock one stalled");
  tick_only_a: assert property (($changed(o_OE_N) || $changed(o_WE_N))
    |-> $rose(o_MCLK_ONE) || $rose(o_MCLK_TWO)) else $error("pin moved off tick");
  drive_turn_a: assert property (o_ED_OE |-> o_OE_N)
    else $error("bus fight");
  cmd_sel_a: assert property (cmd_s |-> !(&o_CS_N))
    else $error("command unselected");
endmodule
bind psmp_top psmp_assertions u_chk (.I_CLK, .I_RST_B, .i_CFG_ADDR, .o_CFG_RDATA, .o_RD_VALID,
  .o_MCLK_ONE, .o_MCLK_TWO, .o_CS_N, .o_OE_N, .o_WE_N, .o_ED_OE);

// >>> psmp_mem_model.sv
`timescale 1ns/1ns
module psmp_mem_model
  import psmp_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic i_cs_n, // Select.
  input wire logic i_oe_n, // Output enable.
  input wire logic i_drv, // Bus driven.
  input wire logic [PSMP_AW-1:0] i_ea, // Address.
  input wire logic [PSMP_DW-1:0] i_ed, // Write data.
  input wire logic [PSMP_BW-1:0] i_be_n, // Byte enables.
  output logic [PSMP_DW-1:0] o_ed // Read data.
);
  logic [PSMP_DW-1:0] mem [16];
  logic [PSMP_DW-1:0] last;
  logic [3:0] a_q;
  // Cleared words, so a partial write leaves a known value.
  initial begin
    last = '0;
    a_q = 4'h0;
    for (int i = 0; i < 16; i++) mem[i] = '0;
  end
  // Address taken while selected; enabled bytes stored while driven.
  always @(posedge i_clk) begin
    if (!i_cs_n) a_q <= i_ea[3:0];
    for (int b = 0; b < PSMP_BW; b++)
      if (i_drv && !i_be_n[b]) mem[a_q][8*b+:8] <= i_ed[8*b+:8];
    last <= o_ed;
  end
  // A released bus flips every cycle, so stale samples never look valid.
  assign o_ed = !i_oe_n ? mem[a_q] : ~last;
endmodule

// >>> psmp_tb_top.sv
`timescale 1ns/1ns
module psmp_tb_top
  import psmp_pkg::*;
;
  logic I_CLK, I_RST_B, i_CFG_WE, i_REQ_VALID, o_REQ_READY, o_RD_VALID, o_BUSY;
  logic o_MCLK_ONE, o_MCLK_TWO, o_ED_OE, o_ADS_RE_N, o_OE_N, o_WE_N;
  logic [31:0] i_CFG_ADDR, i_CFG_WDATA, o_CFG_RDATA;
  logic [1:0] i_CLK2_DIV;
  psmp_req_t i_REQ;
  logic [PSMP_DW-1:0] o_RD_DATA, o_ED_OUT, i_ED_IN;
  logic [PSMP_NSP-1:0] o_CS_N;
  logic [PSMP_AW-1:0] o_EA;
  logic [PSMP_BW-1:0] o_BE_N;
  int err_count, cmp_count, tc, te, n_cs, n_ads, n_oe;
  time c;
  psmp_top dut (.I_CLK, .I_RST_B, .i_CFG_WE, .i_CFG_ADDR, .i_CFG_WDATA, .o_CFG_RDATA,
    .i_CLK2_DIV, .i_REQ_VALID, .o_REQ_READY, .i_REQ, .o_RD_VALID, .o_RD_DATA, .o_BUSY,
    .o_MCLK_ONE, .o_MCLK_TWO, .o_CS_N, .o_EA, .o_BE_N, .o_ED_OUT, .o_ED_OE, .i_ED_IN,
    .o_ADS_RE_N, .o_OE_N, .o_WE_N);
  psmp_mem_model mem (.i_clk(I_CLK), .i_cs_n(o_CS_N[0]), .i_oe_n(o_OE_N), .i_drv(o_ED_OE),
    .i_ea(o_EA), .i_ed(o_ED_OUT), .i_be_n(o_BE_N), .o_ed(i_ED_IN));
  // Input clock at 125 MHz.
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Outputs are read one step after the edge, once its updates landed.
  task automatic tick();
    @(posedge I_CLK);
    #1;
  endtask
  task automatic cfg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    i_CFG_WE <= 1'b1;
    i_CFG_ADDR <= a;
    i_CFG_WDATA <= d;
    @(posedge I_CLK);
    i_CFG_WE <= 1'b0;
  endtask
  // One access on space 0, then a bounded watch of the pins as it runs out.
  task automatic acc(input logic [6:0] cfg, input logic we, input logic [63:0] d);
    cfg_wr(PSMP_SEC_ADDR0, {25'h0, cfg});
    i_REQ <= '{we: we, space: 2'h0, addr: 20'h3, be: 8'hF0, wdata: d};
    i_REQ_VALID <= 1'b1;
    // The request stands until an edge that finds the sequencer idle takes it.
    #1;
    while (!o_REQ_READY) tick();
    @(posedge I_CLK);
    i_REQ_VALID <= 1'b0;
    tc = -1;
    te = -1;
    n_cs = 0;
    n_ads = 0;
    n_oe = 0;
    for (int i = 0; i < 60; i++) begin
      tick();
      if (tc < 0 && !(we ? o_WE_N : o_OE_N)) begin
        tc = i;
        chk({o_BUSY, o_REQ_READY, o_EA}, {2'b10, 20'h3});
      end
      if (te < 0 && (we ? o_ED_OE : o_RD_VALID)) te = i;
      n_cs += !o_CS_N[0];
      n_ads += !o_ADS_RE_N;
      n_oe += !o_OE_N;
      if (o_ED_OE) chk(o_BE_N, 8'h0F);
    end
    // Both events must be seen, so a missing strobe cannot pass as zero latency.
    chk(tc >= 0 && te >= tc, 1'b1);
  endtask
  // Distinct words in every space; the reserved hole keeps nothing.
  task automatic t_cfg();
    logic [31:0] a [5] = '{PSMP_SEC_ADDR0, PSMP_SEC_ADDR1, PSMP_SEC_ADDR2, PSMP_SEC_ADDR3,
      32'h0180_004C};
    for (int i = 0; i < 5; i++) cfg_wr(a[i], 32'hFFFF_FF80 | (i * 9 + 3));
    for (int i = 0; i < 5; i++) begin
      @(posedge I_CLK);
      i_CFG_ADDR <= a[i];
      repeat (2) tick();
      chk(o_CFG_RDATA, i < 4 ? i * 9 + 3 : 0);
    end
  endtask
  task automatic t_rlat();
    for (int r = 0; r < 4; r++) begin
      acc({5'h0, r[1:0]}, 1'b0, 64'h0);
      chk(te - tc, (r + 1) * 2);
      chk(n_ads, 4);
      chk(n_cs, 2);
    end
  endtask
  task automatic t_wlat();
    for (int w = 0; w < 4; w++) begin
      acc({3'h0, w[1:0], 2'h0}, 1'b1, {32'hC0DE_0000 | w, 32'h5555_5555});
      chk(te - tc, w * 2);
    end
    acc(7'h02, 1'b0, 64'h0);
    chk(o_RD_DATA, {32'hC0DE_0003, 32'h0});
  endtask
  task automatic t_mode();
    acc(7'h12, 1'b0, 64'h0);
    chk(n_oe, 6);
    chk(n_cs, n_oe);
    acc(7'h22, 1'b0, 64'h0);
    chk(n_ads, 2);
    acc(7'h20, 1'b1, 64'h0);
    chk(n_ads, 0);
  endtask
  // Clock two at each divide, then a read timed from it.
  task automatic t_clk2();
    for (int k = 0; k < 3; k++) begin
      @(posedge I_CLK);
      i_CLK2_DIV <= k[1:0];
      repeat (20) tick();
      @(posedge o_MCLK_TWO);
      c = $time;
      @(posedge o_MCLK_TWO);
      chk(($time - c) / 8, 2 << k);
    end
    @(posedge I_CLK);
    i_CLK2_DIV <= 2'h1;
    repeat (20) tick();
    acc(7'h42, 1'b0, 64'h0);
    chk(te - tc, 12);
    chk(n_ads, 8);
  endtask
  // The tests need about 1000 cycles; the watchdog allows roughly twelve times that.
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    I_RST_B = 1'b0;
    i_CFG_WE = 1'b0;
    i_CFG_ADDR = 32'h0;
    i_CFG_WDATA = 32'h0;
    i_CLK2_DIV = 2'h0;
    i_REQ_VALID = 1'b0;
    i_REQ = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    repeat (3) @(posedge I_CLK);
    t_cfg();
    t_rlat();
    t_wlat();
    t_mode();
    t_clk2();
    close_out();
  end
endmodule
